//--- hdl/etbd_dev.sv
// Four-channel edge timestamp input module with diagnostic record
//
// Summary of operation
// - New entry at head, older entries shift down
// - Short variant full after fifth entry
// - When full, oldest entry discarded on insert
// - Head module must supply microsecond ticker
// - No interrupts; diagnostics returned only on read
// - Record set 01h full, 00h first four
// - Index 2F01h full, 2F00h first four bytes
// - Index 5005h serves record bytes per subindex
// - Module info: class 1111b, channel info bit
// - Diagnostic bits per channel reads zero
// - Channel count reads four
// - Last four bytes: ticker at generation
// - Image length fixed by variant, no outputs
// - Entry holds ticker value and input states
// - Two enable bytes select rising, falling edges
`timescale 1ns/1ps
`include "etbd_map.svh"

module etbd_dev
  import etbd_pkg::*;
#(
  parameter int DEPTH = `ETBD_DEPTH_SHORT
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // Backplane link
  etbd_if.dev LINK,
  // Input channels
  input wire logic [3:0] DIN_I,
  // Buffer status
  output logic [$clog2(DEPTH+1)-1:0] ENTRY_COUNT_O,
  output logic FULL_O
);

  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [7:0] IMG_LEN = 8'(DEPTH * `ETBD_ENTRY_BYTES);

  // ---------------------------------------------------------------
  // Diagnostic record byte lookup
  // ---------------------------------------------------------------
  function automatic logic [7:0] diag_byte(input logic [7:0] pos,
                                           input logic [31:0] snap);
    logic [7:0] b;
    b = 8'h00;
    if (pos == `ETBD_POS_MODINFO) begin
      b = {3'h0, `ETBD_CHINFO, `ETBD_MODCLASS};
    end else if (pos == `ETBD_POS_CHKIND) begin
      b = {1'h0, `ETBD_CHKIND};
    end else if (pos == `ETBD_POS_DIAG_BITS_PER_CHANNEL) begin
      b = `ETBD_DIAG_BITS_PER_CHANNEL;
    end else if (pos == `ETBD_POS_CHANNEL_COUNT) begin
      b = `ETBD_CHANNEL_COUNT;
    end else if (pos == `ETBD_POS_TICKER) begin
      b = snap[7:0];
    end else if (pos == `ETBD_POS_TICKER + 8'h01) begin
      b = snap[15:8];
    end else if (pos == `ETBD_POS_TICKER + 8'h02) begin
      b = snap[23:16];
    end else if (pos == `ETBD_POS_TICKER + 8'h03) begin
      b = snap[31:24];
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // Edge enable bytes
  // ---------------------------------------------------------------
  logic [3:0] rise_sel_reg;
  logic [3:0] fall_sel_reg;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rise_sel_reg <= 4'h0;
      fall_sel_reg <= 4'h0;
    end else if (LINK.par_wr) begin
      if (LINK.par_sel == `ETBD_SEL_RISE) begin
        rise_sel_reg <= LINK.par_data[3:0];
      end else begin
        fall_sel_reg <= LINK.par_data[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------
  logic [3:0] din_prev_reg;
  logic armed_reg;
  logic [3:0] rise_hit;
  logic [3:0] fall_hit;
  logic capture;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      din_prev_reg <= 4'h0;
      armed_reg <= 1'h0;
    end else begin
      din_prev_reg <= DIN_I;
      armed_reg <= 1'h1;
    end
  end

  assign rise_hit = DIN_I & ~din_prev_reg & rise_sel_reg;
  assign fall_hit = ~DIN_I & din_prev_reg & fall_sel_reg;
  assign capture = armed_reg && ((rise_hit | fall_hit) != 4'h0);

  // ---------------------------------------------------------------
  // Entry shift buffer
  // ---------------------------------------------------------------
  logic [31:0] entry_reg [0:DEPTH-1];
  logic [31:0] entry_next;
  logic [CW-1:0] count_reg;

  assign entry_next = {LINK.ticker[31-`ETBD_TICK_LSB:0], DIN_I};

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      entry_reg[0] <= 32'h0000_0000;
    end else if (capture) begin
      entry_reg[0] <= entry_next;
    end
  end

  generate
    for (genvar i = 1; i < DEPTH; i++) begin : g_shift
      always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          entry_reg[i] <= 32'h0000_0000;
        end else if (capture) begin
          entry_reg[i] <= entry_reg[i-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      count_reg <= '0;
    end else if (capture && count_reg != DEPTH_C) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ENTRY_COUNT_O <= '0;
      FULL_O <= 1'h0;
    end else begin
      ENTRY_COUNT_O <= count_reg;
      FULL_O <= (count_reg == DEPTH_C);
    end
  end

  // ---------------------------------------------------------------
  // Diagnostic ticker snapshot
  // ---------------------------------------------------------------
  logic [31:0] snap_reg;
  logic snap_take;

  assign snap_take = LINK.req_valid && LINK.req_off == 8'h00 &&
    ((LINK.req_kind == ETBD_KIND_RECORD &&
      (LINK.req_sel == `ETBD_REC_FULL ||
       LINK.req_sel == `ETBD_REC_SHORT)) ||
     (LINK.req_kind == ETBD_KIND_INDEX &&
      (LINK.req_sel == `ETBD_IDX_FULL ||
       LINK.req_sel == `ETBD_IDX_SHORT)));

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      snap_reg <= 32'h0000_0000;
    end else if (snap_take) begin
      snap_reg <= LINK.ticker;
    end
  end

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  logic [31:0] rsp_data_next;
  logic rsp_err_next;
  logic [31:0] img_word;
  logic [7:0] img_byte;
  logic [7:0] sub_pos;

  always_comb begin
    img_word = 32'h0000_0000;
    if (int'(LINK.req_off[7:2]) < DEPTH) begin
      img_word = entry_reg[int'(LINK.req_off[7:2])];
    end
    img_byte = img_word[8*LINK.req_off[1:0] +: 8];
  end

  assign sub_pos = LINK.req_off - `ETBD_SUB_FIRST;

  always_comb begin
    rsp_data_next = 32'h0000_0000;
    rsp_err_next = 1'h0;
    case (LINK.req_kind)
      ETBD_KIND_IMAGE: begin
        if (LINK.req_off < IMG_LEN) begin
          rsp_data_next = {24'h00_0000, img_byte};
        end else begin
          rsp_err_next = 1'h1;
        end
      end
      ETBD_KIND_RECORD: begin
        if (LINK.req_sel == `ETBD_REC_FULL &&
            LINK.req_off < `ETBD_DIAG_LEN) begin
          rsp_data_next = {24'h00_0000,
            diag_byte(LINK.req_off, snap_reg)};
        end else if (LINK.req_sel == `ETBD_REC_SHORT &&
                     LINK.req_off < `ETBD_DIAG_SHORT_LEN) begin
          rsp_data_next = {24'h00_0000,
            diag_byte(LINK.req_off, snap_reg)};
        end else begin
          rsp_err_next = 1'h1;
        end
      end
      ETBD_KIND_INDEX: begin
        if (LINK.req_sel == `ETBD_IDX_FULL &&
            LINK.req_off < `ETBD_DIAG_LEN) begin
          rsp_data_next = {24'h00_0000,
            diag_byte(LINK.req_off, snap_reg)};
        end else if (LINK.req_sel == `ETBD_IDX_SHORT &&
                     LINK.req_off < `ETBD_DIAG_SHORT_LEN) begin
          rsp_data_next = {24'h00_0000,
            diag_byte(LINK.req_off, snap_reg)};
        end else begin
          rsp_err_next = 1'h1;
        end
      end
      default: begin
        if (LINK.req_sel != `ETBD_ECAT_IDX) begin
          rsp_err_next = 1'h1;
        end else if (LINK.req_off >= `ETBD_SUB_FIRST &&
                     LINK.req_off <= `ETBD_SUB_LAST) begin
          rsp_data_next = {24'h00_0000,
            diag_byte(sub_pos, snap_reg)};
        end else if (LINK.req_off == `ETBD_SUB_TICKER) begin
          rsp_data_next = LINK.ticker;
        end else begin
          rsp_err_next = 1'h1;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Answer registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LINK.rsp_valid <= 1'h0;
      LINK.rsp_err <= 1'h0;
      LINK.rsp_data <= 32'h0000_0000;
    end else begin
      LINK.rsp_valid <= LINK.req_valid;
      if (LINK.req_valid) begin
        LINK.rsp_err <= rsp_err_next;
        LINK.rsp_data <= rsp_data_next;
      end
    end
  end

endmodule

//--- shared/etbd_map.svh
// Offsets, field values and timing counts of the edge timestamp buffer
`ifndef ETBD_MAP_SVH
`define ETBD_MAP_SVH

// ---------------------------------------------------------------
// Process image
// ---------------------------------------------------------------
`define ETBD_DEPTH_SHORT 5
`define ETBD_DEPTH_LONG 15
`define ETBD_ENTRY_BYTES 4
`define ETBD_CHANNELS 4
`define ETBD_TICK_LSB 4
`define ETBD_SEL_RISE 1'h0
`define ETBD_SEL_FALL 1'h1

// ---------------------------------------------------------------
// Diagnostic record selectors
// ---------------------------------------------------------------
`define ETBD_REC_FULL 16'h0001
`define ETBD_REC_SHORT 16'h0000
`define ETBD_IDX_FULL 16'h2F01
`define ETBD_IDX_SHORT 16'h2F00
`define ETBD_ECAT_IDX 16'h5005
`define ETBD_SUB_FIRST 8'h02
`define ETBD_SUB_LAST 8'h11
`define ETBD_SUB_TICKER 8'h13

// ---------------------------------------------------------------
// Diagnostic record layout and contents
// ---------------------------------------------------------------
`define ETBD_DIAG_LEN 8'h14
`define ETBD_DIAG_SHORT_LEN 8'h04
`define ETBD_POS_MODINFO 8'h01
`define ETBD_POS_CHKIND 8'h04
`define ETBD_POS_DIAG_BITS_PER_CHANNEL 8'h05
`define ETBD_POS_CHANNEL_COUNT 8'h06
`define ETBD_POS_TICKER 8'h10
`define ETBD_MODCLASS 4'hF
`define ETBD_CHINFO 1'h1
`define ETBD_CHKIND 7'h70
`define ETBD_DIAG_BITS_PER_CHANNEL 8'h00
`define ETBD_CHANNEL_COUNT 8'h04

// ---------------------------------------------------------------
// Microsecond ticker timing
// ---------------------------------------------------------------
`define ETBD_CLK_HZ 32'h0098_9680
`define ETBD_TICK_US 32'h0000_0001
`define ETBD_TICK_CYC ((`ETBD_CLK_HZ / 32'h000F_4240) * `ETBD_TICK_US)

`endif

//--- shared/etbd_pkg.sv
// Types shared by both ends of the edge timestamp buffer link
package etbd_pkg;

  // Kind of read access made by the head module
  typedef enum logic [1:0] {
    ETBD_KIND_IMAGE,
    ETBD_KIND_RECORD,
    ETBD_KIND_INDEX,
    ETBD_KIND_SUBINDEX
  } etbd_kind_type;

endpackage

//--- shared/etbd_if.sv
// Backplane link between head module and timestamp input module
`timescale 1ns/1ps
interface etbd_if;
  import etbd_pkg::*;

  logic [31:0] ticker;
  logic req_valid;
  etbd_kind_type req_kind;
  logic [15:0] req_sel;
  logic [7:0] req_off;
  logic par_wr;
  logic par_sel;
  logic [7:0] par_data;
  logic rsp_valid;
  logic rsp_err;
  logic [31:0] rsp_data;

  modport dev (
    input ticker, req_valid, req_kind, req_sel, req_off,
    input par_wr, par_sel, par_data,
    output rsp_valid, rsp_err, rsp_data
  );

  modport head (
    output ticker, req_valid, req_kind, req_sel, req_off,
    output par_wr, par_sel, par_data,
    input rsp_valid, rsp_err, rsp_data
  );
endinterface

//--- hdl/etbd_head.sv
// Head module end: microsecond ticker and read forwarding
`timescale 1ns/1ps
`include "etbd_map.svh"

module etbd_head
  import etbd_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // Backplane link
  etbd_if.head LINK,
  // Read request
  input wire logic REQ_VALID_I,
  input wire etbd_kind_type REQ_KIND_I,
  input wire logic [15:0] REQ_SEL_I,
  input wire logic [7:0] REQ_OFF_I,
  // Edge enable write
  input wire logic PAR_WR_I,
  input wire logic PAR_SEL_I,
  input wire logic [7:0] PAR_DATA_I,
  // Read answer
  output logic RSP_VALID_O,
  output logic RSP_ERR_O,
  output logic [31:0] RSP_DATA_O,
  // Ticker
  output logic [31:0] TICKER_O
);

  // ---------------------------------------------------------------
  // Microsecond ticker
  // ---------------------------------------------------------------
  localparam logic [31:0] TICK_LAST = 32'(`ETBD_TICK_CYC - 1);
  logic [31:0] div_reg;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_reg <= 32'h0000_0000;
      LINK.ticker <= 32'h0000_0000;
      TICKER_O <= 32'h0000_0000;
    end else if (div_reg == TICK_LAST) begin
      div_reg <= 32'h0000_0000;
      LINK.ticker <= LINK.ticker + 32'h0000_0001;
      TICKER_O <= LINK.ticker + 32'h0000_0001;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Request and parameter forwarding
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LINK.req_valid <= 1'h0;
      LINK.req_kind <= ETBD_KIND_IMAGE;
      LINK.req_sel <= 16'h0000;
      LINK.req_off <= 8'h00;
    end else begin
      LINK.req_valid <= REQ_VALID_I;
      if (REQ_VALID_I) begin
        LINK.req_kind <= REQ_KIND_I;
        LINK.req_sel <= REQ_SEL_I;
        LINK.req_off <= REQ_OFF_I;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LINK.par_wr <= 1'h0;
      LINK.par_sel <= 1'h0;
      LINK.par_data <= 8'h00;
    end else begin
      LINK.par_wr <= PAR_WR_I;
      if (PAR_WR_I) begin
        LINK.par_sel <= PAR_SEL_I;
        LINK.par_data <= PAR_DATA_I;
      end
    end
  end

  // ---------------------------------------------------------------
  // Answer capture
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RSP_VALID_O <= 1'h0;
      RSP_ERR_O <= 1'h0;
      RSP_DATA_O <= 32'h0000_0000;
    end else begin
      RSP_VALID_O <= LINK.rsp_valid;
      if (LINK.rsp_valid) begin
        RSP_ERR_O <= LINK.rsp_err;
        RSP_DATA_O <= LINK.rsp_data;
      end
    end
  end

endmodule

//--- sim/etbd_checker.sv
// Link checker for the edge timestamp buffer
`timescale 1ns/1ps
module etbd_checker
  import etbd_pkg::*;
#(
  parameter int DEPTH = 5
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // Head side
  input wire logic [31:0] ticker,
  input wire logic req_valid,
  input wire etbd_kind_type req_kind,
  input wire logic [15:0] req_sel,
  input wire logic [7:0] req_off,
  input wire logic par_wr,
  input wire logic par_sel,
  input wire logic [7:0] par_data,
  // Device side
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [31:0] rsp_data
);
  logic rec_full;
  logic rec_short;
  logic sub_rd;
  assign rec_full = req_valid && ((req_kind == ETBD_KIND_RECORD &&
    req_sel == 16'h0001) || (req_kind == ETBD_KIND_INDEX &&
    req_sel == 16'h2F01));
  assign rec_short = req_valid && ((req_kind == ETBD_KIND_RECORD &&
    req_sel == 16'h0000) || (req_kind == ETBD_KIND_INDEX &&
    req_sel == 16'h2F00));
  assign sub_rd = req_valid && req_kind == ETBD_KIND_SUBINDEX;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_ok(logic [31:0] d);
    ##1 rsp_valid && !rsp_err && rsp_data == d;
  endsequence
  sequence s_refused;
    ##1 rsp_valid && rsp_err && rsp_data == 32'h0000_0000;
  endsequence

  property p_answer_only_on_read;
    1'b1 |-> rsp_valid == $past(req_valid);
  endproperty
  property p_modinfo;
    rec_full && req_off == 8'h01 |-> s_ok(32'h0000_001F);
  endproperty
  property p_chkind;
    rec_full && req_off == 8'h04 |-> s_ok(32'h0000_0070);
  endproperty
  property p_diag_bits_per_channel;
    rec_full && req_off == 8'h05 |-> s_ok(32'h0000_0000);
  endproperty
  property p_channel_count;
    rec_full && req_off == 8'h06 |-> s_ok(32'h0000_0004);
  endproperty
  property p_short_limit;
    rec_short && req_off >= 8'h04 |-> s_refused;
  endproperty
  property p_full_limit;
    rec_full |=> rsp_valid && rsp_err == ($past(req_off) >= 8'h14);
  endproperty
  property p_sub_wrong;
    sub_rd && (req_sel != 16'h5005 || req_off < 8'h02 ||
      req_off == 8'h12 || req_off > 8'h13) |-> s_refused;
  endproperty
  property p_sub_ticker;
    sub_rd && req_sel == 16'h5005 && req_off == 8'h13 |=>
      rsp_valid && !rsp_err && rsp_data == $past(ticker);
  endproperty
  property p_image_limit;
    req_valid && req_kind == ETBD_KIND_IMAGE |=>
      rsp_err == ($past(req_off) >= 4 * DEPTH);
  endproperty
  property p_ticker_step;
    ticker == $past(ticker) || ticker == $past(ticker) + 32'h0000_0001;
  endproperty

  a_answer_only_on_read: assert property (p_answer_only_on_read)
    else $error("answer without matching read");
  a_modinfo: assert property (p_modinfo)
    else $error("module info byte wrong");
  a_chkind: assert property (p_chkind)
    else $error("channel kind byte wrong");
  a_diag_bits_per_channel: assert property (p_diag_bits_per_channel)
    else $error("diag bits byte wrong");
  a_channel_count: assert property (p_channel_count)
    else $error("channel count byte wrong");
  a_short_limit: assert property (p_short_limit)
    else $error("short record served past four bytes");
  a_full_limit: assert property (p_full_limit)
    else $error("full record range wrong");
  a_sub_wrong: assert property (p_sub_wrong)
    else $error("bad subindex accepted");
  a_sub_ticker: assert property (p_sub_ticker)
    else $error("subindex ticker wrong");
  a_image_limit: assert property (p_image_limit)
    else $error("image length wrong");
  a_ticker_step: assert property (p_ticker_step)
    else $error("ticker jumped");
endmodule

//--- sim/edge_timestamp_buffer_diag_tb_top.sv
// Self-checking bench of the edge timestamp buffer link
`timescale 1ns/1ps
module edge_timestamp_buffer_diag_tb_top;
  import etbd_pkg::*;
  localparam int DEPTH = 5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] din = 4'h0;
  logic rq_v = 1'b0;
  etbd_kind_type rq_k = ETBD_KIND_IMAGE;
  logic [15:0] rq_s = 16'h0000;
  logic [7:0] rq_o = 8'h00;
  logic pw = 1'b0;
  logic ps = 1'b0;
  logic [7:0] pd = 8'h00;
  logic rsp_v;
  logic rsp_e;
  logic full;
  logic [31:0] rsp_d;
  logic [31:0] tick_o;
  logic [2:0] count;
  logic [3:0] rise_en = 4'h0;
  logic [3:0] fall_en = 4'h0;
  logic [31:0] model[$];
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;

  // ---------------------------------------------------------------
  // Clock, design and checker
  // ---------------------------------------------------------------
  always #50 clk = ~clk;
  always @(posedge clk) if (rst_n) cyc <= cyc + 1;
  etbd_if link();
  etbd_dev #(.DEPTH(DEPTH)) etbd_dev_i (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .LINK(link), .DIN_I(din), .ENTRY_COUNT_O(count), .FULL_O(full));
  etbd_head etbd_head_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .LINK(link),
    .REQ_VALID_I(rq_v), .REQ_KIND_I(rq_k), .REQ_SEL_I(rq_s),
    .REQ_OFF_I(rq_o), .PAR_WR_I(pw), .PAR_SEL_I(ps), .PAR_DATA_I(pd),
    .RSP_VALID_O(rsp_v), .RSP_ERR_O(rsp_e), .RSP_DATA_O(rsp_d),
    .TICKER_O(tick_o));
  etbd_checker #(.DEPTH(DEPTH)) etbd_checker_i (.CLK_SYS_I(clk),
    .RST_N_I(rst_n), .ticker(link.ticker), .req_valid(link.req_valid),
    .req_kind(link.req_kind), .req_sel(link.req_sel),
    .req_off(link.req_off), .par_wr(link.par_wr), .par_sel(link.par_sel),
    .par_data(link.par_data), .rsp_valid(link.rsp_valid),
    .rsp_err(link.rsp_err), .rsp_data(link.rsp_data));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_val(logic [31:0] got, logic [31:0] exp, string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_time(logic [31:0] got, logic [31:0] exp, string m);
    n_checks++;
    if ($isunknown(got) || got + 1 < exp || got > exp + 1) begin
      fail_count++;
      $display("unexpected %0t %s got %h near %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [7:0] diag_byte(int o);
    case (o)
      1: return 8'h1F;
      4: return 8'h70;
      6: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction
  task automatic rd(etbd_kind_type k, logic [15:0] s, logic [7:0] o,
    output logic [31:0] d, output logic e);
    int n;
    @(posedge clk);
    rq_v <= 1'b1;
    rq_k <= k;
    rq_s <= s;
    rq_o <= o;
    @(posedge clk);
    rq_v <= 1'b0;
    d = 'x;
    e = 1'bx;
    for (n = 0; n < 8; n++) begin
      @(negedge clk);
      if (rsp_v === 1'b1) begin
        d = rsp_d;
        e = rsp_e;
        n = 8;
      end
    end
  endtask
  task automatic chk_rd(etbd_kind_type k, logic [15:0] s, logic [7:0] o,
    logic [31:0] ed, logic ee);
    logic [31:0] d;
    logic e;
    rd(k, s, o, d, e);
    chk_val(d, ed, "read data");
    chk_val(32'(e), 32'(ee), "refusal");
  endtask
  task automatic set_en(logic sel, logic [7:0] v);
    @(posedge clk);
    pw <= 1'b1;
    ps <= sel;
    pd <= v;
    @(posedge clk);
    pw <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic step_din(logic [3:0] v);
    logic [3:0] p;
    p = din;
    @(posedge clk);
    din <= v;
    if (|((~p & v & rise_en) | (p & ~v & fall_en))) begin
      model.push_front({28'(cyc / 10), v});
      if (model.size() > DEPTH) model.pop_back();
    end
    repeat (3) @(posedge clk);
    chk_val(32'(count), model.size(), "count");
    chk_val(32'(full), 32'(model.size() == DEPTH), "full");
  endtask
  task automatic check_image();
    logic [31:0] w;
    logic [31:0] d;
    logic e;
    for (int k = 0; k < DEPTH; k++) begin
      for (int b = 0; b < 4; b++) begin
        rd(ETBD_KIND_IMAGE, 16'h0000, 8'(4 * k + b), d, e);
        w[8*b +: 8] = d[7:0];
      end
      if (k < model.size()) begin
        chk_val(32'(w[3:0]), 32'(model[k][3:0]), "entry inputs");
        chk_time(32'(w[31:4]), 32'(model[k][31:4]), "entry time");
      end else begin
        chk_val(w, 32'h0000_0000, "empty slot");
      end
    end
    chk_rd(ETBD_KIND_IMAGE, 16'h0000, 8'(4 * DEPTH), 0, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    int unsigned seed;
    logic [7:0] r;
    logic [31:0] d;
    logic [31:0] w;
    logic [31:0] tk;
    logic e;
    seed = $urandom(31);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    check_image();
    set_en(1'b0, 8'hF1);
    rise_en = 4'h1;
    set_en(1'b1, 8'h02);
    fall_en = 4'h2;
    for (int i = 0; i < 6; i++) begin
      step_din(4'(32'h0401_0310 >> (4 * i)));
    end
    r = 8'($urandom) | 8'h01;
    set_en(1'b0, r);
    rise_en = r[3:0];
    r = 8'($urandom) | 8'h01;
    set_en(1'b1, r);
    fall_en = r[3:0];
    repeat (12) step_din(din ^ 4'($urandom_range(15, 1)));
    repeat (6) step_din(din ^ 4'h1);
    check_image();
    for (int i = 0; i < 2; i++) begin
      tk = 32'((cyc + 2) / 10);
      for (int o = 0; o < 16; o++) begin
        chk_rd(i ? ETBD_KIND_INDEX : ETBD_KIND_RECORD,
          i ? 16'h2F01 : 16'h0001, 8'(o), diag_byte(o), 1'b0);
      end
      for (int b = 0; b < 4; b++) begin
        rd(i ? ETBD_KIND_INDEX : ETBD_KIND_RECORD,
          i ? 16'h2F01 : 16'h0001, 8'(16 + b), d, e);
        w[8*b +: 8] = d[7:0];
      end
      chk_time(w, tk, "record ticker");
      for (int o = 0; o < 5; o++) begin
        chk_rd(i ? ETBD_KIND_INDEX : ETBD_KIND_RECORD,
          i ? 16'h2F00 : 16'h0000, 8'(o),
          o < 4 ? diag_byte(o) : 8'h00, o >= 4);
      end
    end
    chk_rd(ETBD_KIND_RECORD, 16'h0002, 8'h00, 0, 1'b1);
    chk_rd(ETBD_KIND_INDEX, 16'h2F02, 8'h00, 0, 1'b1);
    chk_rd(ETBD_KIND_SUBINDEX, 16'h5006, 8'h03, 0, 1'b1);
    for (int s = 1; s < 21; s++) begin
      if (s == 19) begin
        chk_time(tick_o, 32'(cyc / 10), "ticker out");
        tk = 32'((cyc + 2) / 10);
        rd(ETBD_KIND_SUBINDEX, 16'h5005, 8'h13, d, e);
        chk_time(d, tk, "live ticker");
      end else begin
        chk_rd(ETBD_KIND_SUBINDEX, 16'h5005, 8'(s),
          (s >= 2 && s <= 17) ? diag_byte(s - 2) : 8'h00,
          !(s >= 2 && s <= 17));
      end
    end
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("unexpected %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
